// File: hw/bank_track_if.sv
// interface between the command host and one bank tracker
`timescale 1ns/100ps
`default_nettype none
interface bank_track_if;
	// command strobe to this bank
	logic issue;
	sdram_host_pkg::cmd_t cmd;
	logic auto_pre;
	// bank state back to the host
	sdram_host_pkg::bank_state_t state;
	modport host (output issue, output cmd, output auto_pre, input state);
	modport bank (input issue, input cmd, input auto_pre, output state);
endinterface
`default_nettype wire

// File: hw/bank_tracker.sv
// per-bank state tracker with timing down-counter
`timescale 1ns/100ps
`default_nettype none
module bank_tracker (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// command side
	bank_track_if.bank trk
);
	// ***************
	// state and timer
	// ***************
	logic [sdram_host_pkg::CNT_W-1:0] cnt_reg; // remaining cycles
	sdram_host_pkg::bank_state_t state_reg;
	assign trk.state = state_reg;

	// state and counter update
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_reg <= sdram_host_pkg::BANK_IDLE;
			cnt_reg <= '0;
		end
		else if (trk.issue)
		begin
			unique case (trk.cmd)
				sdram_host_pkg::CMD_ACTIVATE:
				begin
					// start activating, timed
					state_reg <= sdram_host_pkg::BANK_ACTIVATING;
					cnt_reg <= sdram_host_pkg::CNT_W'(sdram_host_pkg::ACTIVATE_CYC - 1);
				end
				sdram_host_pkg::CMD_READ, sdram_host_pkg::CMD_WRITE:
				begin
					if (trk.auto_pre)
					begin
						// auto precharge held for precharge time
						state_reg <= sdram_host_pkg::BANK_AUTO_PRE;
						cnt_reg <= sdram_host_pkg::CNT_W'(sdram_host_pkg::PRECHARGE_CYC - 1);
					end
					else if (trk.cmd == sdram_host_pkg::CMD_READ)
						state_reg <= sdram_host_pkg::BANK_READ;
					else
						state_reg <= sdram_host_pkg::BANK_WRITE;
				end
				sdram_host_pkg::CMD_PRECHARGE:
				begin
					// idle bank untouched
					if (state_reg != sdram_host_pkg::BANK_IDLE)
					begin
						state_reg <= sdram_host_pkg::BANK_PRECHARGING;
						cnt_reg <= sdram_host_pkg::CNT_W'(sdram_host_pkg::PRECHARGE_CYC - 1);
					end
				end
				sdram_host_pkg::CMD_TERMINATE:
				begin
					// stopped burst leaves row open
					state_reg <= sdram_host_pkg::BANK_ACTIVE;
				end
				default:
				begin
					state_reg <= state_reg;
				end
			endcase
		end
		else if (cnt_reg != '0)
			cnt_reg <= cnt_reg - 1'b1;
		else
		begin
			// timed states expire
			unique case (state_reg)
				sdram_host_pkg::BANK_ACTIVATING: state_reg <= sdram_host_pkg::BANK_ACTIVE;
				sdram_host_pkg::BANK_AUTO_PRE: state_reg <= sdram_host_pkg::BANK_IDLE;
				sdram_host_pkg::BANK_PRECHARGING: state_reg <= sdram_host_pkg::BANK_IDLE;
				default: state_reg <= state_reg;
			endcase
		end
	end
endmodule
`default_nettype wire

// File: hw/sdram_cmd_host.sv
// command host: accepts user requests, drives sdram strobes legally
`timescale 1ns/100ps
`default_nettype none
module sdram_cmd_host #(
	parameter int ADDR_W = sdram_host_pkg::ADDR_W
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// user request port
	input wire logic req_valid,
	input wire logic [2:0] req_cmd,
	input wire logic [1:0] req_bank,
	input wire logic [ADDR_W-1:0] req_addr,
	output logic req_ready,
	output logic req_done,
	output logic req_reject,
	// self-refresh exit notice from the user side
	input wire logic self_refresh_exit,
	// sdram pins
	output logic cke,
	output logic cs_n,
	output logic ras_n,
	output logic cas_n,
	output logic we_n,
	output logic [1:0] bank_sel,
	output logic [ADDR_W-1:0] addr
);
	// ********************
	// bank trackers
	// ********************
	bank_track_if trk [sdram_host_pkg::BANKS] ();
	logic [sdram_host_pkg::BANKS-1:0] bank_idle; // per-bank idle flags
	logic [sdram_host_pkg::BANKS-1:0] bank_pre_ok; // per-bank precharge allowed
	logic [sdram_host_pkg::BANKS-1:0] hit; // per-bank command select
	logic issue; // a command goes out this cycle
	sdram_host_pkg::cmd_t cmd_in;
	sdram_host_pkg::bank_state_t sel_state; // state of addressed bank
	sdram_host_pkg::bank_state_t sel_states [sdram_host_pkg::BANKS];
	logic [1:0] last_burst_bank_reg; // bank of most recent burst
	logic burst_open_reg; // most recent burst still running
	logic pre_all; // precharge of every bank
	logic legal; // request is legal now

	assign cmd_in = sdram_host_pkg::cmd_t'(req_cmd);
	assign pre_all = req_addr[sdram_host_pkg::AUTO_PRECHARGE_BIT];

	genvar gi;
	generate
		for (gi = 0; gi < sdram_host_pkg::BANKS; gi++)
		begin : g_bank
			// fan a command out to addressed bank, all banks, or for terminate the most recent burst bank
			always_comb
			begin
				if (cmd_in == sdram_host_pkg::CMD_PRECHARGE && pre_all)
					hit[gi] = 1'b1;
				else if (cmd_in == sdram_host_pkg::CMD_TERMINATE)
					hit[gi] = (last_burst_bank_reg == 2'(gi));
				else
					hit[gi] = (req_bank == 2'(gi));
			end
			assign trk[gi].issue = issue && hit[gi];
			assign trk[gi].cmd = cmd_in;
			assign trk[gi].auto_pre = req_addr[sdram_host_pkg::AUTO_PRECHARGE_BIT];
			assign sel_states[gi] = trk[gi].state;
			assign bank_idle[gi] = (trk[gi].state == sdram_host_pkg::BANK_IDLE);
			assign bank_pre_ok[gi] = (trk[gi].state == sdram_host_pkg::BANK_IDLE)
				|| (trk[gi].state == sdram_host_pkg::BANK_ACTIVE)
				|| (trk[gi].state == sdram_host_pkg::BANK_READ)
				|| (trk[gi].state == sdram_host_pkg::BANK_WRITE);
			bank_tracker u_bank (
				.clk(clk),
				.reset_n(reset_n),
				.trk(trk[gi])
			);
		end
	endgenerate

	assign sel_state = sel_states[req_bank];

	// ********************
	// device-wide timing
	// ********************
	sdram_host_pkg::dev_state_t dev_state_reg;
	logic [sdram_host_pkg::CNT_W-1:0] dev_cnt_reg; // remaining device-wide cycles
	logic [sdram_host_pkg::CNT_W-1:0] exit_cnt_reg; // self-refresh exit wait

	// refresh, mode load and precharge-all timers
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			dev_state_reg <= sdram_host_pkg::DEV_NORMAL;
			dev_cnt_reg <= '0;
		end
		else if (issue && cmd_in == sdram_host_pkg::CMD_REFRESH)
		begin
			dev_state_reg <= sdram_host_pkg::DEV_REFRESHING;
			dev_cnt_reg <= sdram_host_pkg::CNT_W'(sdram_host_pkg::REFRESH_CYC - 1);
		end
		else if (issue && cmd_in == sdram_host_pkg::CMD_MODE_LOAD)
		begin
			dev_state_reg <= sdram_host_pkg::DEV_MODE_ACCESS;
			dev_cnt_reg <= sdram_host_pkg::CNT_W'(sdram_host_pkg::MODE_LOAD_CYC - 1);
		end
		else if (issue && cmd_in == sdram_host_pkg::CMD_PRECHARGE && pre_all)
		begin
			dev_state_reg <= sdram_host_pkg::DEV_PRE_ALL;
			dev_cnt_reg <= sdram_host_pkg::CNT_W'(sdram_host_pkg::PRECHARGE_CYC - 1);
		end
		else if (dev_cnt_reg != '0)
			dev_cnt_reg <= dev_cnt_reg - 1'b1;
		else
			dev_state_reg <= sdram_host_pkg::DEV_NORMAL;
	end

	// self-refresh exit hold-off
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			exit_cnt_reg <= '0;
		else if (self_refresh_exit)
			exit_cnt_reg <= sdram_host_pkg::CNT_W'(sdram_host_pkg::SELF_REFRESH_EXIT_CYC);
		else if (exit_cnt_reg != '0)
			exit_cnt_reg <= exit_cnt_reg - 1'b1;
	end

	// ********************
	// legality check
	// ********************
	// only commands listed for the current state pass
	always_comb
	begin
		legal = 1'b0;
		if (dev_state_reg != sdram_host_pkg::DEV_NORMAL || exit_cnt_reg != '0)
			legal = (cmd_in == sdram_host_pkg::CMD_NOP);
		else
		begin
			unique case (cmd_in)
				sdram_host_pkg::CMD_NOP: legal = 1'b1;
				sdram_host_pkg::CMD_ACTIVATE: legal = (sel_state == sdram_host_pkg::BANK_IDLE);
				sdram_host_pkg::CMD_READ, sdram_host_pkg::CMD_WRITE:
					legal = (sel_state == sdram_host_pkg::BANK_ACTIVE)
						|| (sel_state == sdram_host_pkg::BANK_READ)
						|| (sel_state == sdram_host_pkg::BANK_WRITE);
				sdram_host_pkg::CMD_PRECHARGE:
					legal = pre_all ? (&bank_pre_ok) : bank_pre_ok[req_bank];
				sdram_host_pkg::CMD_TERMINATE: legal = burst_open_reg;
				sdram_host_pkg::CMD_REFRESH, sdram_host_pkg::CMD_MODE_LOAD: legal = &bank_idle;
			endcase
		end
	end
	assign issue = req_valid && legal && cmd_in != sdram_host_pkg::CMD_NOP;

	// most recent burst tracking
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			last_burst_bank_reg <= 2'h0;
			burst_open_reg <= 1'b0;
		end
		else if (issue && (cmd_in == sdram_host_pkg::CMD_READ || cmd_in == sdram_host_pkg::CMD_WRITE))
		begin
			last_burst_bank_reg <= req_bank;
			burst_open_reg <= !req_addr[sdram_host_pkg::AUTO_PRECHARGE_BIT];
		end
		else if (issue && (cmd_in == sdram_host_pkg::CMD_TERMINATE
			|| (cmd_in == sdram_host_pkg::CMD_PRECHARGE && (pre_all || req_bank == last_burst_bank_reg))))
			burst_open_reg <= 1'b0;
	end

	// ********************
	// pin drive
	// ********************
	// strobes registered; nop when nothing to send
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			{cs_n, ras_n, cas_n, we_n} <= sdram_host_pkg::PIN_INHIBIT;
			bank_sel <= 2'h0;
			addr <= '0;
			cke <= 1'b0;
		end
		else
		begin
			cke <= 1'b1;
			bank_sel <= req_bank;
			addr <= req_addr;
			if (!issue)
				{cs_n, ras_n, cas_n, we_n} <= sdram_host_pkg::PIN_NOP;
			else
			begin
				unique case (cmd_in)
					sdram_host_pkg::CMD_ACTIVATE: {cs_n, ras_n, cas_n, we_n} <= sdram_host_pkg::PIN_ACTIVE;
					sdram_host_pkg::CMD_READ: {cs_n, ras_n, cas_n, we_n} <= sdram_host_pkg::PIN_READ;
					sdram_host_pkg::CMD_WRITE: {cs_n, ras_n, cas_n, we_n} <= sdram_host_pkg::PIN_WRITE;
					sdram_host_pkg::CMD_PRECHARGE: {cs_n, ras_n, cas_n, we_n} <= sdram_host_pkg::PIN_PRECHARGE;
					sdram_host_pkg::CMD_TERMINATE: {cs_n, ras_n, cas_n, we_n} <= sdram_host_pkg::PIN_TERMINATE;
					sdram_host_pkg::CMD_REFRESH: {cs_n, ras_n, cas_n, we_n} <= sdram_host_pkg::PIN_REFRESH;
					sdram_host_pkg::CMD_MODE_LOAD: {cs_n, ras_n, cas_n, we_n} <= sdram_host_pkg::PIN_MODE_LOAD;
					default: {cs_n, ras_n, cas_n, we_n} <= sdram_host_pkg::PIN_NOP;
				endcase
			end
		end
	end

	// request handshake flags
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			req_ready <= 1'b0;
			req_done <= 1'b0;
			req_reject <= 1'b0;
		end
		else
		begin
			req_ready <= 1'b1;
			req_done <= req_valid && legal;
			req_reject <= req_valid && !legal;
		end
	end
endmodule
`default_nettype wire

// File: hw/sdram_host_pkg.sv
// package of constants and types for the sdram command host
// What this block does
// - chip select high ignores the command
// - select low, strobes high is no-operation
// - activate in idle bank starts activating
// - refresh and mode load need all idle
// - read or write in active bank starts burst
// - burst terminate stops most recent burst
// - rules hold only with clock gate high
// - no same-bank command in busy states
// - refresh lasts refresh cycle, only nops
// - mode load lasts mode load time, nops
// - precharge-all lasts precharge time, nops
// - never issue illegal state-command pairs
// - address bit ten selects auto precharge
// - address bit ten selects precharge all
package sdram_host_pkg;
	// clock period in picoseconds
	localparam int CLK_PERIOD_PS = 8000;
	// timing figures in nanoseconds, plain defaults
	localparam int PRECHARGE_TIME_NS = 20;
	localparam int ACTIVATE_TO_ACCESS_TIME_NS = 20;
	localparam int REFRESH_CYCLE_TIME_NS = 66;
	localparam int MODE_LOAD_TIME_NS = 16;
	localparam int SELF_REFRESH_EXIT_TIME_NS = 67;
	// cycle counts, rounded up
	localparam int PRECHARGE_CYC = (PRECHARGE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ACTIVATE_CYC = (ACTIVATE_TO_ACCESS_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int REFRESH_CYC = (REFRESH_CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int MODE_LOAD_CYC = (MODE_LOAD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SELF_REFRESH_EXIT_CYC = (SELF_REFRESH_EXIT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// widths and bank count
	localparam int CNT_W = 5;
	localparam int ADDR_W = 13;
	localparam int BANKS = 4;
	// address bit ten position
	localparam int AUTO_PRECHARGE_BIT = 10;
	// strobe encodings {cs_n, ras_n, cas_n, we_n}
	localparam logic [3:0] PIN_INHIBIT = 4'hF;
	localparam logic [3:0] PIN_NOP = 4'h7;
	localparam logic [3:0] PIN_ACTIVE = 4'h3;
	localparam logic [3:0] PIN_READ = 4'h5;
	localparam logic [3:0] PIN_WRITE = 4'h4;
	localparam logic [3:0] PIN_PRECHARGE = 4'h2;
	localparam logic [3:0] PIN_TERMINATE = 4'h6;
	localparam logic [3:0] PIN_REFRESH = 4'h1;
	localparam logic [3:0] PIN_MODE_LOAD = 4'h0;
	// user command codes
	typedef enum logic [2:0] {
		CMD_NOP = 3'h0,
		CMD_ACTIVATE = 3'h1,
		CMD_READ = 3'h2,
		CMD_WRITE = 3'h3,
		CMD_PRECHARGE = 3'h4,
		CMD_TERMINATE = 3'h5,
		CMD_REFRESH = 3'h6,
		CMD_MODE_LOAD = 3'h7
	} cmd_t;
	// tracked bank state
	typedef enum logic [2:0] {
		BANK_IDLE,
		BANK_ACTIVATING,
		BANK_ACTIVE,
		BANK_READ,
		BANK_WRITE,
		BANK_AUTO_PRE,
		BANK_PRECHARGING
	} bank_state_t;
	// device-wide state
	typedef enum logic [1:0] {
		DEV_NORMAL,
		DEV_REFRESHING,
		DEV_MODE_ACCESS,
		DEV_PRE_ALL
	} dev_state_t;
endpackage

// File: verification/sdram_cmd_host_sva.sv
// assertion checker for the sdram command host
`timescale 1ns/100ps
`default_nettype none
module sdram_cmd_host_sva #(
	parameter int ADDR_W = 13
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// user request port
	input wire logic req_valid,
	input wire logic [2:0] req_cmd,
	input wire logic [1:0] req_bank,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic req_done,
	input wire logic req_reject,
	input wire logic self_refresh_exit,
	// sdram pins
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [1:0] bank_sel
);
	// ****
	// helpers
	// ****
	logic [3:0] pins; // strobes as one code
	logic [1:0] act_bank; // bank of latest activate request
	assign pins = {cs_n, ras_n, cas_n, we_n};
	// remember the bank of the latest activate
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
			act_bank <= 2'h0;
		else if (req_valid && req_cmd == 3'h1)
			act_bank <= req_bank;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// accepted activate
	sequence s_act;
		req_valid && req_cmd == 3'h1 ##1 req_done;
	endsequence
	// accepted precharge of all banks
	sequence s_pre_all;
		req_valid && req_cmd == 3'h4 && req_addr[10] ##1 req_done;
	endsequence
	// ****
	// properties
	// ****
	AST_ONE_ANSWER: assert property (req_valid && req_cmd != 3'h0 |=> req_done != req_reject)
		else $error("request not answered exactly once");
	AST_IDLE_NOP: assert property (reset_n && !req_valid |=> pins == 4'h7 && !req_done && !req_reject)
		else $error("pins not idle without a request");
	AST_REJECT_NOP: assert property (req_reject |-> pins == 4'h7)
		else $error("refused request reached the pins");
	AST_ACT_PINS: assert property (s_act |-> pins == 4'h3 && bank_sel == $past(req_bank))
		else $error("activate pins wrong");
	AST_ACT_WAIT: assert property (s_act ##[0:2] (req_valid && req_cmd == 3'h2 && req_bank == act_bank) |=> req_reject)
		else $error("read accepted while row opening");
	AST_CKE_UP: assert property ($past(reset_n) |-> cke)
		else $error("clock gate low in operation");
	AST_SR_EXIT: assert property (self_refresh_exit |-> ##2 (pins == 4'h7) [*7])
		else $error("command during self refresh exit");
	AST_REFRESH_QUIET: assert property (pins == 4'h1 |=> (pins == 4'h7) [*8])
		else $error("command during refresh");
	AST_MODE_QUIET: assert property (pins == 4'h0 |=> (pins == 4'h7) [*2])
		else $error("command during mode load");
	AST_PRE_ALL: assert property (s_pre_all |=> (pins == 4'h7) [*2])
		else $error("command during precharge of all banks");
endmodule
bind sdram_cmd_host sdram_cmd_host_sva #(.ADDR_W(ADDR_W)) sva (
	.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank),
	.req_addr(req_addr), .req_done(req_done), .req_reject(req_reject), .self_refresh_exit(self_refresh_exit),
	.cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bank_sel(bank_sel)
);
`default_nettype wire

// File: verification/sdram_dev_model.sv
// behavioural sdram device tracking bank states from the pins
`timescale 1ns/100ps
`default_nettype none
module sdram_dev_model (
	// clock
	input wire logic clk,
	// sdram pins
	input wire logic cke,
	input wire logic cs_n,
	input wire logic ras_n,
	input wire logic cas_n,
	input wire logic we_n,
	input wire logic [1:0] bank_sel,
	input wire logic [12:0] addr,
	// illegal commands seen
	output int violations
);
	// ****
	// state: 0 idle 1 opening 2 open 3 read 4 write 5 auto close 6 closing
	// ****
	int st [4]; // per-bank state
	int cnt [4]; // per-bank timer
	int dev_cnt = 0; // device-wide timer
	int last_b = 0; // bank of latest burst
	initial
	begin
		violations = 0;
		foreach (st[i]) {st[i], cnt[i]} = {32'd0, 32'd0};
	end
	// set one bank state and timer
	task automatic go(input int b, input int s, input int c);
		st[b] = s;
		cnt[b] = c;
	endtask
	// register one command, timers retire first
	always @(posedge clk)
	begin
		for (int i = 0; i < 4; i++)
		begin
			if (cnt[i] == 1) st[i] = (st[i] == 1) ? 2 : 0;
			if (cnt[i] != 0) cnt[i]--;
		end
		if (dev_cnt != 0) dev_cnt--;
		if (cke && !cs_n && {ras_n, cas_n, we_n} != 3'h7)
			apply(int'(bank_sel));
	end
	// decode against tracked state
	task automatic apply(input int b);
		int busy;
		busy = 0;
		foreach (st[i]) busy += (st[i] != 0);
		if (dev_cnt != 0) violations++;
		else case ({ras_n, cas_n, we_n})
			3'h3: if (st[b] == 0) go(b, 1, sdram_host_pkg::ACTIVATE_CYC); else violations++;
			3'h5, 3'h4: if (st[b] >= 2 && st[b] <= 4)
			begin
				go(b, addr[10] ? 5 : (we_n ? 3 : 4), addr[10] ? sdram_host_pkg::PRECHARGE_CYC : 0);
				last_b = b;
			end
			else violations++;
			3'h2: if (addr[10])
			begin
				foreach (st[i]) if (st[i] == 1 || st[i] >= 5) violations++; else go(i, 0, 0);
				dev_cnt = sdram_host_pkg::PRECHARGE_CYC;
			end
			else if (st[b] >= 2 && st[b] <= 4) go(b, 6, sdram_host_pkg::PRECHARGE_CYC);
			else if (st[b] != 0) violations++;
			3'h6: if (st[last_b] == 3 || st[last_b] == 4) st[last_b] = 2;
			default:
			begin
				if (busy != 0) violations++;
				dev_cnt = we_n ? sdram_host_pkg::REFRESH_CYC : sdram_host_pkg::MODE_LOAD_CYC;
			end
		endcase
	endtask
endmodule
`default_nettype wire

// File: verification/test_sdram_cmd_host.sv
// self-checking testbench for the sdram command host
`timescale 1ns/100ps
`default_nettype none
module test_sdram_cmd_host;
	logic clk, reset_n, req_valid, self_refresh_exit; // bench-driven controls
	logic [2:0] req_cmd; // request code
	logic [1:0] req_bank; // request bank
	logic [12:0] req_addr; // request address
	logic req_ready, req_done, req_reject, cke, cs_n, ras_n, cas_n, we_n; // design outputs
	logic [1:0] bank_sel; // bank pins
	logic [12:0] addr; // address pins
	int violations, n_errors = 0, tests_run = 0, cycles = 0; // counters
	sdram_cmd_host #(.ADDR_W(13)) dut (.clk(clk), .reset_n(reset_n), .req_valid(req_valid), .req_cmd(req_cmd),
		.req_bank(req_bank), .req_addr(req_addr), .req_ready(req_ready), .req_done(req_done), .req_reject(req_reject),
		.self_refresh_exit(self_refresh_exit), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.bank_sel(bank_sel), .addr(addr));
	sdram_dev_model dev (.clk(clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
		.bank_sel(bank_sel), .addr(addr), .violations(violations));
	// 8 ns clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// compare and count
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one request; ok picks done or refusal, p the strobe code when issued
	task automatic rq(input int c, input int b, input int a, input int ok, input int p);
		@(posedge clk);
		req_valid <= 1'b1;
		req_cmd <= 3'(c);
		req_bank <= 2'(b);
		req_addr <= 13'(a);
		@(posedge clk);
		req_valid <= 1'b0;
		@(negedge clk);
		check({req_done, req_reject}, {1'(ok), 1'(ok == 0)});
		check({cs_n, ras_n, cas_n, we_n}, (ok != 0) ? 4'(p) : 4'h7);
		if (ok != 0) check({bank_sel, addr}, 15'({b, 13'(a)}));
	endtask
	// codes: 1 act 2 read 3 write 4 precharge 5 terminate 6 refresh 7 mode
	task automatic t_open_read();
		rq(0, 0, 0, 1, 'h7);
		rq(1, 0, 'h0123, 1, 'h3);
		rq(2, 0, 0, 0, 0);
		rq(2, 0, 'h0005, 1, 'h5);
		rq(5, 0, 0, 1, 'h6);
		rq(5, 0, 0, 0, 0);
	endtask
	task automatic t_replace();
		rq(3, 0, 'h0008, 1, 'h4);
		rq(2, 0, 'h0009, 1, 'h5);
		rq(3, 0, 'h000A, 1, 'h4);
		rq(4, 0, 0, 1, 'h2);
		rq(1, 0, 0, 0, 0);
		rq(1, 0, 'h0001, 1, 'h3);
		rq(2, 0, 0, 0, 0);
		rq(2, 0, 'h0002, 1, 'h5);
		rq(4, 0, 0, 1, 'h2);
	endtask
	task automatic t_idle_and_auto();
		rq(4, 1, 0, 1, 'h2);
		rq(1, 1, 0, 1, 'h3);
		rq(2, 1, 0, 0, 0);
		rq(2, 1, 'h0400, 1, 'h5);
		rq(2, 1, 0, 0, 0);
		rq(1, 1, 0, 1, 'h3);
	endtask
	task automatic t_pre_all();
		rq(6, 0, 0, 0, 0);
		rq(1, 0, 0, 1, 'h3);
		rq(3, 1, 0, 1, 'h4);
		rq(4, 2, 'h0400, 1, 'h2);
		rq(6, 0, 0, 0, 0);
		rq(6, 0, 0, 1, 'h1);
	endtask
	task automatic t_refresh_mode();
		repeat (4) rq(1, 3, 0, 0, 0);
		rq(7, 0, 'h0032, 1, 'h0);
		rq(1, 3, 0, 0, 0);
		rq(1, 3, 0, 1, 'h3);
		rq(3, 3, 'h0400, 0, 0);
		rq(3, 3, 'h0400, 1, 'h4);
	endtask
	task automatic t_sr_exit();
		@(posedge clk);
		self_refresh_exit <= 1'b1;
		@(posedge clk);
		self_refresh_exit <= 1'b0;
		rq(1, 2, 0, 0, 0);
		repeat (10) @(posedge clk);
		rq(1, 2, 'h0007, 1, 'h3);
	endtask
	// verdict
	task automatic end_of_test();
		$display("errors %0d comparisons %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			n_errors++;
			end_of_test();
		end
	end
	// main sequence
	initial
	begin
		{reset_n, req_valid, self_refresh_exit, req_cmd, req_bank, req_addr} = '0;
		repeat (6) @(posedge clk);
		check({cke, cs_n, ras_n, cas_n, we_n}, 5'h0F);
		reset_n <= 1'b1;
		@(posedge clk);
		@(negedge clk);
		check({cke, req_ready, cs_n, ras_n, cas_n, we_n}, 6'h37);
		t_open_read();
		t_replace();
		t_idle_and_auto();
		t_pre_all();
		t_refresh_mode();
		t_sr_exit();
		check(16'(violations), 16'h0000);
		end_of_test();
	end
endmodule
`default_nettype wire
